/* File: common/sysref_mon_pkg.sv */
// Shared constants and types for the reference window monitor
package sysref_mon_pkg;

    // Delay-line structure: taps every 20 ps from -60 ps to +140 ps
    localparam int unsigned TAP_SPACING_PS = 20;
    localparam int unsigned TAP_LEAD_PS    = 60;
    localparam int unsigned TAP_N          = 11;
    localparam int unsigned BIN_N          = 5;
    localparam int unsigned CFG_W          = 5;
    localparam int unsigned IDX_W          = 10;
    localparam int unsigned ADDR_W         = 12;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DET_CLEAR  = 10'h102;
    localparam logic [IDX_W-1:0] IDX_MON_FLAGS  = 10'h140;
    localparam logic [IDX_W-1:0] IDX_PIN_FUNC   = 10'h146;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h150;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h151;

    // Field positions
    localparam int unsigned FLG_DET_BIT = 6;
    localparam int unsigned FLG_ANY_BIT = 5;
    localparam int unsigned CLR_DET_BIT = 6;
    localparam int unsigned IRQ_DET_BIT = 0;
    localparam int unsigned IRQ_WIN_BIT = 1;
    localparam int unsigned IRQ_W       = 2;

    // Reset values
    localparam logic [7:0]        RST_MON_FLAGS = 8'h00;
    localparam logic [CFG_W-1:0]  RST_PIN_FUNC  = 5'h00;
    localparam logic [IRQ_W-1:0]  RST_IRQ       = 2'h0;

    // Pin-function codes
    localparam logic [CFG_W-1:0] CFG_REF_ONLY     = 5'h00;
    localparam logic [CFG_W-1:0] CFG_REF_PDN      = 5'h03;
    localparam logic [CFG_W-1:0] CFG_REF_EXTREF   = 5'h04;
    localparam logic [CFG_W-1:0] CFG_HOP          = 5'h05;
    localparam logic [CFG_W-1:0] CFG_REF_ONLY_B   = 5'h08;
    localparam logic [CFG_W-1:0] CFG_REF_OVR      = 5'h09;
    localparam logic [CFG_W-1:0] CFG_PDN_ONLY     = 5'h0A;
    localparam logic [CFG_W-1:0] CFG_PDN_OVR      = 5'h0B;
    localparam logic [CFG_W-1:0] CFG_OVR_ONLY     = 5'h12;

    typedef enum logic [2:0] {
        ROLE_UNUSED = 3'h0,
        ROLE_REF    = 3'h1,
        ROLE_HOP    = 3'h2,
        ROLE_PDN    = 3'h3,
        ROLE_EXTREF = 3'h4,
        ROLE_OVR    = 3'h5
    } pin_role_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drv_t;

    typedef struct packed {
        logic             det;
        logic [BIN_N-1:0] win;
    } mon_flags_t;

endpackage

/* File: rtl/sysref_window_monitor.sv */
// Reference presence and phase-window monitor with pin-function selector
module sysref_window_monitor
    import sysref_mon_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic                   o_pready,
    output logic [31:0]            o_prdata,
    output logic                   o_pslverr,
    // Delay-line copies of pin zero, tap 0 earliest
    input  wire logic [TAP_N-1:0]  i_ref_taps,
    // General pins
    input  wire logic              i_pin0_in,
    input  wire logic              i_pin1_in,
    output pin_drv_t               o_pin0,
    output pin_drv_t               o_pin1,
    // Pin functions
    input  wire logic              i_overrange,
    output logic [1:0]             o_hop_sel,
    output logic                   o_global_pdn,
    output logic                   o_ext_ref,
    // Interrupt
    output logic                   o_irq
);

    // Role of a general pin for a given code
    // Codes not listed leave both pins undriven
    function automatic pin_role_t pin_role(
        input logic [CFG_W-1:0] cfg,
        input logic             pin_one
    );
        pin_role_t r;
        r = ROLE_UNUSED;
        if (!pin_one) begin
            unique case (cfg)
                CFG_REF_ONLY,
                CFG_REF_PDN,
                CFG_REF_EXTREF,
                CFG_REF_ONLY_B,
                CFG_REF_OVR:    r = ROLE_REF;
                CFG_HOP:        r = ROLE_HOP;
                CFG_PDN_ONLY,
                CFG_PDN_OVR:    r = ROLE_PDN;
                CFG_OVR_ONLY:   r = ROLE_OVR;
                default:        r = ROLE_UNUSED;
            endcase
        end else begin
            unique case (cfg)
                CFG_REF_PDN:    r = ROLE_PDN;
                CFG_REF_EXTREF: r = ROLE_EXTREF;
                CFG_HOP:        r = ROLE_HOP;
                CFG_REF_OVR,
                CFG_PDN_OVR:    r = ROLE_OVR;
                default:        r = ROLE_UNUSED;
            endcase
        end
        return r;
    endfunction

    // Tap k samples at (20k - 60) ps; a change between k and k+1 lies in bin k/2
    // Either polarity counts, so a falling glitch still marks its window
    function automatic logic [BIN_N-1:0] window_hits(
        input logic [TAP_N-1:0] taps
    );
        logic [BIN_N-1:0] h;
        h = '0;
        for (int k = 0; k < TAP_N - 1; k++) begin
            if (taps[k] ^ taps[k+1]) begin
                h[k/2] = 1'b1;
            end
        end
        return h;
    endfunction

    // Write strobe for one register index
    function automatic logic wr_to(
        input logic             en,
        input logic [IDX_W-1:0] cur,
        input logic [IDX_W-1:0] target
    );
        return en && (cur == target);
    endfunction

    // Register state
    logic [CFG_W-1:0] pin_cfg_q;
    logic [CFG_W-1:0] pin_cfg_d;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_stat_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_mask_d;
    logic [31:0]      prdata_q;
    logic [31:0]      prdata_d;

    // Capture and monitor state
    logic [TAP_N:0]   cap_fall_q;
    logic [TAP_N:0]   cap_fall_d;
    logic [TAP_N:0]   cap_q;
    logic [TAP_N:0]   cap_d;
    logic             ref_prev_q;
    logic             ref_prev_d;
    mon_flags_t       flags_q;
    mon_flags_t       flags_d;

    // Pin state
    pin_drv_t         pin0_q;
    pin_drv_t         pin0_d;
    pin_drv_t         pin1_q;
    pin_drv_t         pin1_d;
    logic [1:0]       hop_q;
    logic [1:0]       hop_d;
    logic             pdn_q;
    logic             pdn_d;
    logic             ext_ref_q;
    logic             ext_ref_d;

    // Decoded bus and event terms
    logic             bus_setup;
    logic             bus_access;
    logic             addr_hit;
    logic             wr_en;
    logic [IDX_W-1:0] idx;
    logic             ref_rise;
    logic [BIN_N-1:0] hits_now;
    logic             win_any;
    logic             det_clear;
    logic             det_event;
    logic             win_event;
    pin_role_t        role0;
    pin_role_t        role1;
    logic [7:0]       flags_rd;

    assign role0 = pin_role(pin_cfg_q, 1'b0);
    assign role1 = pin_role(pin_cfg_q, 1'b1);

    // APB decode; registers sit in byte lane 0
    assign idx        = i_paddr[ADDR_W-1:2];
    assign bus_setup  = i_psel && !i_penable;
    assign bus_access = i_psel && i_penable;
    always_comb begin
        unique case (idx)
            IDX_DET_CLEAR,
            IDX_MON_FLAGS,
            IDX_PIN_FUNC,
            IDX_IRQ_STATUS,
            IDX_IRQ_MASK: addr_hit = (i_paddr[1:0] == 2'h0);
            default:      addr_hit = 1'b0;
        endcase
    end
    // Only byte lane 0 holds register bits, so its strobe gates every write
    assign wr_en     = bus_access && i_pwrite && addr_hit && i_pstrb[0];
    assign det_clear = wr_to(wr_en, idx, IDX_DET_CLEAR) && i_pwdata[CLR_DET_BIT];

    // No wait states; read data is prepared in the setup cycle
    assign o_pready  = 1'b1;
    assign o_pslverr = bus_access && !addr_hit;
    assign o_prdata  = prdata_q;

    // Falling-edge capture of the pin and its tap copies
    always_comb begin
        cap_fall_d = '0;
        if (role0 == ROLE_REF) begin
            cap_fall_d = {i_pin0_in, i_ref_taps};
        end
    end

    // Sampling on the falling edge keeps the window centred on the capture edge
    always_ff @(negedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_fall_q <= '0;
        end else begin
            cap_fall_q <= cap_fall_d;
        end
    end

    // Monitor flags
    assign ref_rise = cap_q[TAP_N] && !ref_prev_q;
    assign hits_now = window_hits(cap_q[TAP_N-1:0]);
    assign win_any  = |flags_q.win;
    // Presence event only on the first rise after a clear
    assign det_event = ref_rise && !flags_q.det;
    assign win_event = ref_rise && (|hits_now);

    always_comb begin
        cap_d      = cap_fall_q;
        ref_prev_d = cap_q[TAP_N];
        flags_d    = flags_q;
        if (ref_rise) begin
            flags_d.win = hits_now;
        end
        // Set wins over a clear in the same cycle
        if (ref_rise) begin
            flags_d.det = 1'b1;
        end else if (det_clear) begin
            flags_d.det = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_q      <= '0;
            ref_prev_q <= 1'b0;
            flags_q    <= '0;
        end else begin
            cap_q      <= cap_d;
            ref_prev_q <= ref_prev_d;
            flags_q    <= flags_d;
        end
    end

    // Flags register image; bit 7 reads as zero
    always_comb begin
        flags_rd              = RST_MON_FLAGS;
        flags_rd[FLG_DET_BIT] = flags_q.det;
        flags_rd[FLG_ANY_BIT] = win_any;
        flags_rd[BIN_N-1:0]   = flags_q.win;
    end

    // Software registers and interrupt
    always_comb begin
        pin_cfg_d  = pin_cfg_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        prdata_d   = prdata_q;
        if (wr_to(wr_en, idx, IDX_PIN_FUNC)) begin
            pin_cfg_d = i_pwdata[CFG_W-1:0];
        end
        if (wr_to(wr_en, idx, IDX_IRQ_MASK)) begin
            irq_mask_d = i_pwdata[IRQ_W-1:0];
        end
        if (wr_to(wr_en, idx, IDX_IRQ_STATUS)) begin
            irq_stat_d = irq_stat_q & ~i_pwdata[IRQ_W-1:0];
        end
        // Events applied after the clear so a coincident event is kept
        if (det_event) begin
            irq_stat_d[IRQ_DET_BIT] = 1'b1;
        end
        if (win_event) begin
            irq_stat_d[IRQ_WIN_BIT] = 1'b1;
        end
        if (bus_setup && !i_pwrite) begin
            prdata_d = '0;
            // Misaligned or unmapped reads return zero
            if (addr_hit) begin
                unique case (idx)
                    IDX_MON_FLAGS:  prdata_d[7:0]       = flags_rd;
                    IDX_PIN_FUNC:   prdata_d[CFG_W-1:0] = pin_cfg_q;
                    IDX_IRQ_STATUS: prdata_d[IRQ_W-1:0] = irq_stat_q;
                    IDX_IRQ_MASK:   prdata_d[IRQ_W-1:0] = irq_mask_q;
                    default:        prdata_d            = '0;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_cfg_q  <= RST_PIN_FUNC;
            irq_mask_q <= RST_IRQ;
            irq_stat_q <= RST_IRQ;
            prdata_q   <= '0;
        end else begin
            pin_cfg_q  <= pin_cfg_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
            prdata_q   <= prdata_d;
        end
    end

    // Level output straight from registers, no added cycle of latency
    assign o_irq = |(irq_stat_q & irq_mask_q);

    // Pin functions; outputs lag the pins by one cycle
    always_comb begin
        pin0_d     = '0;
        pin1_d     = '0;
        hop_d      = 2'h0;
        pdn_d      = 1'b0;
        ext_ref_d  = 1'b0;
        if (role0 == ROLE_OVR) begin
            pin0_d.oe  = 1'b1;
            pin0_d.out = i_overrange;
        end
        if (role1 == ROLE_OVR) begin
            pin1_d.oe  = 1'b1;
            pin1_d.out = i_overrange;
        end
        if (role0 == ROLE_HOP) begin
            hop_d = {i_pin1_in, i_pin0_in};
        end
        if (role0 == ROLE_PDN) begin
            pdn_d = i_pin0_in;
        end else if (role1 == ROLE_PDN) begin
            pdn_d = i_pin1_in;
        end
        if (role1 == ROLE_EXTREF) begin
            ext_ref_d = i_pin1_in;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin0_q    <= '0;
            pin1_q    <= '0;
            hop_q     <= 2'h0;
            pdn_q     <= 1'b0;
            ext_ref_q <= 1'b0;
        end else begin
            pin0_q    <= pin0_d;
            pin1_q    <= pin1_d;
            hop_q     <= hop_d;
            pdn_q     <= pdn_d;
            ext_ref_q <= ext_ref_d;
        end
    end

    assign o_pin0       = pin0_q;
    assign o_pin1       = pin1_q;
    assign o_hop_sel    = hop_q;
    assign o_global_pdn = pdn_q;
    assign o_ext_ref    = ext_ref_q;

endmodule

/* File: verif/ref_source_model.sv */
// Behavioural reference source: pin zero and its delay-line copies
module ref_source_model
    import sysref_mon_pkg::*;
(
    // Clock, request and resulting pin
    input  wire logic        i_clk_sys,
    input  wire logic        i_go,
    input  wire logic [3:0]  i_edge_pos,
    output logic             o_pin,
    output logic [TAP_N-1:0] o_taps
);
    timeunit 1ns;
    timeprecision 1ps;
    // Moves after the rising edge, settled long before the falling capture
    always @(posedge i_clk_sys) begin
        o_pin <= i_go;
        // Early taps see the old low level on the first high cycle only
        o_taps <= !i_go ? '0 : o_pin ? '1 : 11'h7FF << (i_edge_pos + 4'h1);
    end
endmodule

/* File: verif/sysref_window_monitor_props.sv */
// Port-level assertions for the reference window monitor
module sysref_window_monitor_props
    import sysref_mon_pkg::*;
(
    // Watched ports
    input wire logic              i_clk_sys,
    input wire logic              i_rst_n,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic [3:0]        i_pstrb,
    input wire logic [31:0]       o_prdata,
    input wire logic              i_pin0_in,
    input wire logic              i_pin1_in,
    input wire logic              i_overrange,
    input wire pin_drv_t          o_pin0,
    input wire logic [1:0]        o_hop_sel,
    input wire logic              o_global_pdn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [CFG_W-1:0] cfg_q;
    logic             acc;
    assign acc = i_psel && i_penable;
    // Shadow of the pin-function field, so pin roles can be predicted
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q <= 5'h00;
        end else if (acc && i_pwrite && i_pstrb[0] && i_paddr == 12'h518) begin
            cfg_q <= i_pwdata[4:0];
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Two cycles of a stable code cover the pin-output register behind the role decode
    sequence held(logic [4:0] c);
        $past(cfg_q) == c && $past(cfg_q, 2) == c;
    endsequence
    sequence rd_flags;
        acc && !i_pwrite && i_paddr == 12'h500;
    endsequence
    a_sum_or_bits: assert property (rd_flags |-> o_prdata[5] == |o_prdata[4:0])
        else $error("summary bit differs from window OR");
    a_one_window: assert property (rd_flags |-> $onehot0(o_prdata[4:0]) && !o_prdata[7])
        else $error("window flags not one-hot");
    a_cfg_readback: assert property (acc && !i_pwrite && i_paddr == 12'h518 |->
        o_prdata == {27'h0, cfg_q}) else $error("pin-function readback wrong");
    a_hop_follows: assert property (held(5'h05) |->
        o_hop_sel == $past({i_pin1_in, i_pin0_in})) else $error("hop selects not following");
    a_ovr_pin_zero: assert property (held(5'h12) |->
        o_pin0.oe && o_pin0.out == $past(i_overrange)) else $error("overrange not on pin zero");
    a_pdn_pin_zero: assert property (held(5'h0A) |-> o_global_pdn == $past(i_pin0_in))
        else $error("power-down not from pin zero");
    a_pdn_pin_one: assert property (held(5'h03) |-> o_global_pdn == $past(i_pin1_in))
        else $error("power-down not from pin one");
    a_ref_pin_free: assert property (held(5'h00) |-> !o_pin0.oe && o_hop_sel == 2'h0)
        else $error("reference pin driven");
    cover property (rd_flags ##0 o_prdata[6]);
    cover property (held(5'h05));
    cover property (held(5'h12) ##1 o_pin0.out);
endmodule

/* File: verif/sysref_window_monitor_tb.sv */
// Self-checking bench for the reference window monitor
module sysref_window_monitor_tb
    import sysref_mon_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic             go, use_src, src_pin, pdn, ext_ref;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rnd, exp_r;
    logic [3:0]       pos, strb;
    logic [1:0]       hop;
    logic [TAP_N-1:0] taps;
    pin_drv_t         pin0, pin1;
    int               fails, checks_done, k;
    logic [11:0]      regs [5] = '{12'h500, 12'h518, 12'h540, 12'h544, 12'h408};
    logic [4:0]       codes [10] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0A,
                                     5'h0B, 5'h12, 5'h1F};
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    ref_source_model src (.i_clk_sys(clk_sys), .i_go(go), .i_edge_pos(pos), .o_pin(src_pin),
                          .o_taps(taps));
    sysref_window_monitor dut (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_ref_taps(taps),
        .i_pin0_in(use_src ? src_pin : rnd[0]), .i_pin1_in(rnd[1]), .o_pin0(pin0),
        .o_pin1(pin1), .i_overrange(rnd[2]), .o_hop_sel(hop), .o_global_pdn(pdn),
        .o_ext_ref(ext_ref), .o_irq(irq));
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic err);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        n = 0;
        while (pready !== 1'b1) begin
            n++;
            @(posedge clk_sys);
        end
        cmp("wait states", 32'h0, 32'(n));
        cmp("pslverr", {31'h0, err}, {31'h0, pslverr});
        if (!w) cmp("prdata", exp, prdata);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Interrupt is combinational of registers: let the edge's updates land
    task automatic chk_irq(input logic e);
        #1;
        cmp("irq", {31'h0, e}, {31'h0, irq});
    endtask
    function automatic logic [31:0] flags_for(input int kk, input logic det);
        return {25'h0, det, 1'b1, 5'(1 << (kk / 2))};
    endfunction
    // Pin one carries overrange for the two codes that give it that role
    function automatic logic [1:0] pin1_exp(input logic [4:0] c, input logic ovr);
        logic oe;
        oe = (c == 5'h09) || (c == 5'h0B);
        return {oe && ovr, oe};
    endfunction
    task automatic rise(input int kk);
        @(posedge clk_sys);
        go <= 1'b1;
        pos <= 4'(kk);
        repeat (4) @(posedge clk_sys);
        go <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100_000;
        fails++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'ha714));
        // Pin stimulus thread inherits its seed from this one
        fork
            forever begin
                @(posedge clk_sys);
                rnd <= $urandom;
            end
        join_none
        {rst_n, psel, penable, pwrite, paddr, pwdata, go, pos} = '0;
        strb = 4'hF;
        use_src = 1'b1;
        fails = 0;
        checks_done = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (regs[i]) xfer(1'b0, regs[i], 32'h0, 32'h0, 1'b0);
        xfer(1'b0, 12'h600, 32'h0, 32'h0, 1'b1);
        xfer(1'b0, 12'h501, 32'h0, 32'h0, 1'b1);
        xfer(1'b1, 12'h500, 32'hFF, 32'h0, 1'b0);
        xfer(1'b0, 12'h500, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, 12'h544, 32'h3, 32'h0, 1'b0);
        for (int i = 0; i < 13; i++) begin
            k = (i < 10) ? i : int'($urandom_range(9));
            rise(k);
            xfer(1'b0, 12'h500, 32'h0, flags_for(k, 1'b1), 1'b0);
            if (i == 0) begin
                xfer(1'b0, 12'h501, 32'h0, 32'h0, 1'b1);
                xfer(1'b0, 12'h540, 32'h0, 32'h3, 1'b0);
                chk_irq(1'b1);
                xfer(1'b1, 12'h540, 32'h3, 32'h0, 1'b0);
                chk_irq(1'b0);
            end
        end
        chk_irq(1'b1);
        xfer(1'b1, 12'h544, 32'h0, 32'h0, 1'b0);
        chk_irq(1'b0);
        xfer(1'b1, 12'h544, 32'h3, 32'h0, 1'b0);
        xfer(1'b1, 12'h408, 32'h40, 32'h0, 1'b0);
        xfer(1'b0, 12'h500, 32'h0, flags_for(k, 1'b0), 1'b0);
        rise(9);
        xfer(1'b0, 12'h540, 32'h0, 32'h3, 1'b0);
        xfer(1'b1, 12'h540, 32'h3, 32'h0, 1'b0);
        chk_irq(1'b0);
        use_src <= 1'b0;
        foreach (codes[i]) begin
            xfer(1'b1, 12'h518, {24'h0, 3'h0, codes[i]}, 32'h0, 1'b0);
            xfer(1'b0, 12'h518, 32'h0, {27'h0, codes[i]}, 1'b0);
            repeat (12) @(posedge clk_sys);
            exp_r = rnd;
            #1;
            cmp("pin1", {30'h0, pin1_exp(codes[i], exp_r[2])}, {30'h0, pin1});
            cmp("ext_ref", {31'h0, codes[i] == 5'h04 && exp_r[1]}, {31'h0, ext_ref});
        end
        // Strobe low on byte 0 leaves the field alone
        @(posedge clk_sys);
        strb <= 4'hE;
        xfer(1'b1, 12'h518, 32'h5, 32'h0, 1'b0);
        strb <= 4'hF;
        xfer(1'b0, 12'h518, 32'h0, 32'h1F, 1'b0);
        use_src <= 1'b1;
        xfer(1'b1, 12'h518, 32'h0, 32'h0, 1'b0);
        rise(7);
        xfer(1'b1, 12'h518, 32'h5, 32'h0, 1'b0);
        rise(1);
        xfer(1'b0, 12'h500, 32'h0, flags_for(7, 1'b1), 1'b0);
        // Device reset in mid-run must drop every flag and the field
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        xfer(1'b0, 12'h500, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, 12'h518, 32'h0, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule
bind sysref_window_monitor sysref_window_monitor_props props (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .i_pin0_in(i_pin0_in), .i_pin1_in(i_pin1_in),
    .i_overrange(i_overrange), .o_pin0(o_pin0), .o_hop_sel(o_hop_sel),
    .o_global_pdn(o_global_pdn));
